// >>> logic/vdq_qualifier.sv
// Vector debug event qualifier: watchpoints, prefix breakpoints/step, debug-state behaviour, APB registers
//
// Function
// RULE_01 - Watchpoint matches never block the memory access
// RULE_02 - First-fault non-first active match records in register
// RULE_03 - First-fault first active element match raises event
// RULE_04 - Non-fault loads never raise events, record matches
// RULE_05 - Inactive element accesses never raise watchpoint events
// RULE_06 - Ordinary predicated active matches raise watchpoint events
// RULE_07 - Recorded matches return data, clear first-fault elements
// RULE_08 - Prefix before breakpoint or halt is legal
// RULE_09 - Breakpoint on legal prefix fires, alone or paired
// RULE_10 - Illegal prefix or prefixed breakpoint: either outcome
// RULE_11 - Stepping prefix covers pair or prefix only
// RULE_12 - Vector state accessible while halted in debug
// RULE_13 - Listed instructions behave normally in debug state
// RULE_14 - Compare-not-equal normal, corrupts debug link/status
// RULE_15 - Other instructions: undefined, no-op or normal
// RULE_16 - Qualification per element using mask, kind, first
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "vdq_consts.svh"
module vdq_qualifier
  import vdq_pkg::*;
#(
  parameter int NELEM = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vdq_wp_req_type wp_req,
  input wire vdq_commit_type commit,
  input wire vdq_dbg_instr_type dbg_instr,
  input wire logic halted,
  input wire logic ffr_write_en,
  input wire logic [7:0] ffr_write_val,
  output logic access_proceed,
  output logic wp_event,
  output logic [7:0] ffr_clear,
  output logic bkpt_exc,
  output logic step_done,
  output logic step_covers_pair,
  output logic vstate_access_ok,
  output vdq_dbg_action_type dbg_action,
  output logic dbg_action_valid,
  output logic dbg_regs_corrupt,
  output logic flags_unknown,
  output logic irq
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [`VDQ_CTRL_W-1:0] ctrl_r;
  logic [31:0] bkpt_addr_r;
  logic [`VDQ_ST_W-1:0] status_r;
  logic [`VDQ_ST_W-1:0] irq_en_r;
  logic [7:0] ffr_r;
  logic [7:0] wp_elem_r;
  logic wr_stb;
  logic [`VDQ_ST_W-1:0] clr_stb;
  logic [`VDQ_ST_W-1:0] set_stb;
  logic [`VDQ_ST_W-1:0] status_nxt;
  logic [`VDQ_ST_W-1:0] irq_en_nxt;
  logic addr_ok;

  // Writes land on the access edge only, while pready already stands high
  assign wr_stb = psel && penable && pready && pwrite && !pslverr;
  assign clr_stb = (wr_stb && paddr == `VDQ_OFF_IRQ_CLR) ? pwdata[`VDQ_ST_W-1:0] : `VDQ_ST_RESET;
  assign addr_ok = (paddr == `VDQ_OFF_CTRL) || (paddr == `VDQ_OFF_BKPT_ADDR) || (paddr == `VDQ_OFF_STATUS) ||
                   (paddr == `VDQ_OFF_IRQ_EN) || (paddr == `VDQ_OFF_IRQ_CLR) || (paddr == `VDQ_OFF_FFR) ||
                   (paddr == `VDQ_OFF_WP_ELEM);

  // ****************************************************************
  // Per-element watchpoint qualification
  // ****************************************************************
  logic [NELEM-1:0] act;
  logic [NELEM-1:0] hit;
  logic [NELEM-1:0] first_oh;
  logic [NELEM-1:0] raise_vec;
  logic [NELEM-1:0] rec_vec;
  logic [NELEM-1:0] rec_low;
  logic [NELEM-1:0] rec_fill;
  logic wp_en;

  assign wp_en = ctrl_r[`VDQ_CTRL_WP_EN];
  assign act = wp_req.active[NELEM-1:0];
  // Lowest active element as one-hot; two's complement isolates it in one adder
  assign first_oh = act & (~act + {{(NELEM-1){1'b0}}, 1'b1}); // see RULE_16

  genvar gi;
  generate
    for (gi = 0; gi < NELEM; gi++) begin : g_elem
      // Inactive lanes can never hit, whatever the match bit says
      assign hit[gi] = wp_req.valid && wp_en && act[gi] && wp_req.match[gi] && wp_req.nonspec[gi]; // see RULE_05
      always_comb begin
        unique case (wp_req.kind)
          VDQ_LD_FIRST_FAULT: begin
            raise_vec[gi] = hit[gi] && first_oh[gi]; // see RULE_03
            rec_vec[gi] = hit[gi] && !first_oh[gi]; // see RULE_02
          end
          VDQ_LD_NON_FAULT: begin
            raise_vec[gi] = 1'b0; // see RULE_04
            rec_vec[gi] = hit[gi]; // see RULE_04
          end
          VDQ_LD_NORMAL: begin
            raise_vec[gi] = hit[gi]; // see RULE_06
            rec_vec[gi] = 1'b0;
          end
          default: begin
            raise_vec[gi] = 1'b0;
            rec_vec[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // Recording at an element invalidates it and every later element
  assign rec_low = rec_vec & (~rec_vec + {{(NELEM-1){1'b0}}, 1'b1});
  assign rec_fill = (|rec_vec) ? ~(rec_low - {{(NELEM-1){1'b0}}, 1'b1}) : '0; // see RULE_07

  // The access always proceeds; qualification only reports, never gates memory
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_proceed <= 1'b0;
    end else begin
      access_proceed <= wp_req.valid; // see RULE_01
    end
  end

  // Event pulse and the first-fault clear mask, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_event <= 1'b0;
      ffr_clear <= 8'h00;
    end else begin
      wp_event <= |raise_vec; // see RULE_06
      ffr_clear <= 8'(rec_fill); // see RULE_07
    end
  end

  // First-fault register: the clear from a recorded match beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ffr_r <= 8'hFF;
    end else if (|rec_vec) begin
      ffr_r <= (ffr_write_en ? ffr_write_val : ffr_r) & ~8'(rec_fill); // see RULE_02
    end else if (ffr_write_en) begin
      ffr_r <= ffr_write_val;
    end
  end

  // Remember which element raised the last event, for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_elem_r <= 8'h00;
    end else if (|raise_vec) begin
      wp_elem_r <= 8'(raise_vec);
    end
  end

  // ****************************************************************
  // Prefix breakpoints and single-step
  // ****************************************************************
  logic legal_prefix;
  logic addr_hit;
  logic bkpt_hit;

  // A prefix ahead of a breakpoint or halt instruction counts as legal
  assign legal_prefix = commit.is_prefix && (commit.prefix_legal || commit.next_is_brk_hlt); // see RULE_08
  assign addr_hit = commit.valid && ctrl_r[`VDQ_CTRL_BKPT_EN] && commit.pc == bkpt_addr_r;
  // Illegal-prefix cases pick the loose outcome from a control bit, both being allowed
  assign bkpt_hit = addr_hit && (legal_prefix ||
                    ((commit.is_prefix || commit.is_prefixed) && ctrl_r[`VDQ_CTRL_BKPT_LOOSE])); // see RULE_09 RULE_10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bkpt_exc <= 1'b0;
    end else begin
      bkpt_exc <= bkpt_hit; // see RULE_09
    end
  end

  // Step span on a prefix is a software choice; other commits step one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_done <= 1'b0;
      step_covers_pair <= 1'b0;
    end else begin
      step_done <= commit.valid && commit.stepping;
      step_covers_pair <= commit.valid && commit.stepping && commit.is_prefix &&
                          ctrl_r[`VDQ_CTRL_STEP_PAIR]; // see RULE_11
    end
  end

  // ****************************************************************
  // Debug-state instruction behaviour
  // ****************************************************************
  vdq_dbg_action_type act_nxt;
  logic corrupt_nxt;
  logic flags_nxt;
  logic [1:0] pol;

  assign pol = ctrl_r[`VDQ_CTRL_DBG_POL_HI:`VDQ_CTRL_DBG_POL_LO];

  always_comb begin
    act_nxt = VDQ_ACT_NORMAL;
    corrupt_nxt = 1'b0;
    flags_nxt = 1'b0;
    if (dbg_instr.valid && halted) begin
      unique case (dbg_instr.cls)
        VDQ_CLS_LISTED: act_nxt = VDQ_ACT_NORMAL; // see RULE_13
        VDQ_CLS_COMPARE_NOT_EQUAL_INSTR: begin
          act_nxt = VDQ_ACT_NORMAL;
          corrupt_nxt = 1'b1; // see RULE_14
        end
        VDQ_CLS_OTHER_PLAIN, VDQ_CLS_OTHER_PROCESSOR_STATE, VDQ_CLS_OTHER_FLAGS: begin
          // Policy picks one allowed outcome; executed ones still carry side effects
          act_nxt = (pol == `VDQ_POL_UNDEF) ? VDQ_ACT_UNDEF :
                    (pol == `VDQ_POL_NOP) ? VDQ_ACT_NOP : VDQ_ACT_NORMAL; // see RULE_15
          corrupt_nxt = (act_nxt == VDQ_ACT_NORMAL) && dbg_instr.cls == VDQ_CLS_OTHER_PROCESSOR_STATE; // see RULE_15
          flags_nxt = (act_nxt == VDQ_ACT_NORMAL) && dbg_instr.cls == VDQ_CLS_OTHER_FLAGS; // see RULE_15
        end
        default: act_nxt = VDQ_ACT_UNDEF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_action <= VDQ_ACT_NORMAL;
      dbg_action_valid <= 1'b0;
      dbg_regs_corrupt <= 1'b0;
      flags_unknown <= 1'b0;
      vstate_access_ok <= 1'b0;
    end else begin
      dbg_action <= act_nxt;
      dbg_action_valid <= dbg_instr.valid && halted;
      dbg_regs_corrupt <= corrupt_nxt; // see RULE_14
      flags_unknown <= flags_nxt;
      vstate_access_ok <= halted; // see RULE_12
    end
  end

  // ****************************************************************
  // APB registers and interrupt
  // ****************************************************************
  // Control and enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `VDQ_CTRL_RESET;
      bkpt_addr_r <= 32'h00000000;
      irq_en_r <= `VDQ_ST_RESET;
    end else if (wr_stb) begin
      if (paddr == `VDQ_OFF_CTRL) ctrl_r <= pwdata[`VDQ_CTRL_W-1:0];
      if (paddr == `VDQ_OFF_BKPT_ADDR) bkpt_addr_r <= pwdata;
      if (paddr == `VDQ_OFF_IRQ_EN) irq_en_r <= pwdata[`VDQ_ST_W-1:0];
    end
  end

  // Event sources for the sticky status, gathered once every producer is declared
  assign set_stb[`VDQ_ST_WP_EVENT] = |raise_vec;
  assign set_stb[`VDQ_ST_FFR_REC] = |rec_vec;
  assign set_stb[`VDQ_ST_BKPT] = bkpt_hit;
  assign set_stb[`VDQ_ST_DBG_CORRUPT] = corrupt_nxt;

  // Next status and enable, so the registered interrupt never lags an enable write
  assign status_nxt = (status_r & ~clr_stb) | set_stb;
  assign irq_en_nxt = (wr_stb && paddr == `VDQ_OFF_IRQ_EN) ? pwdata[`VDQ_ST_W-1:0] : irq_en_r;

  // Sticky status: a new event in the clearing cycle survives the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= `VDQ_ST_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Interrupt output registered from the next status and next enable values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_nxt & irq_en_nxt);
    end
  end

  // No wait states: read data captured in setup, pready high in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      unique case (paddr)
        `VDQ_OFF_CTRL: prdata <= {26'h0, ctrl_r};
        `VDQ_OFF_BKPT_ADDR: prdata <= bkpt_addr_r;
        `VDQ_OFF_STATUS: prdata <= {28'h0, status_r};
        `VDQ_OFF_IRQ_EN: prdata <= {28'h0, irq_en_r};
        `VDQ_OFF_FFR: prdata <= {24'h0, ffr_r};
        `VDQ_OFF_WP_ELEM: prdata <= {24'h0, wp_elem_r};
        default: prdata <= 32'h00000000;
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ACCESS_PROCEEDS: assert property (wp_req.valid |=> access_proceed) // see RULE_01
    else $error("access blocked by watchpoint");
  AST_FF_LATER_NO_EVENT: assert property (wp_req.valid && wp_req.kind == VDQ_LD_FIRST_FAULT &&
    !(|(hit & first_oh)) && |hit |=> !wp_event && ffr_clear != 8'h00) // see RULE_02
    else $error("first-fault later element raised event");
  AST_FF_FIRST_EVENT: assert property (wp_req.kind == VDQ_LD_FIRST_FAULT && |(hit & first_oh) |=> wp_event) // see RULE_03
    else $error("first active element match without event");
  AST_NF_NO_EVENT: assert property (wp_req.kind == VDQ_LD_NON_FAULT |=> !wp_event) // see RULE_04
    else $error("non-fault load raised event");
  AST_INACTIVE_QUIET: assert property (wp_req.active == 8'h00 |=> !wp_event && ffr_clear == 8'h00) // see RULE_05
    else $error("inactive elements raised event");
  AST_NORMAL_EVENT: assert property (wp_req.kind == VDQ_LD_NORMAL && |hit |=> // see RULE_06
    wp_event && status_r[`VDQ_ST_WP_EVENT])
    else $error("ordinary match missed event");
  AST_FFR_CLEARED: assert property (|rec_vec && !ffr_write_en |=> (ffr_r & ffr_clear) == 8'h00) // see RULE_07
    else $error("first-fault elements not cleared");
  AST_LEGAL_PREFIX_BKPT: assert property (addr_hit && commit.is_prefix && commit.next_is_brk_hlt |=> // see RULE_08 RULE_09
    bkpt_exc)
    else $error("legal prefix breakpoint missed");
  AST_STEP_SPAN: assert property (step_covers_pair |-> step_done) // see RULE_11
    else $error("pair step without step");
  AST_HALT_ACCESS: assert property ($rose(halted) |=> vstate_access_ok) // see RULE_12
    else $error("vector state not accessible while halted");
  AST_LISTED_NORMAL: assert property (dbg_instr.valid && halted && dbg_instr.cls == VDQ_CLS_LISTED |=>
    dbg_action == VDQ_ACT_NORMAL && !dbg_regs_corrupt) // see RULE_13
    else $error("listed instruction changed in debug state");
  AST_COMPARE_NOT_EQUAL_INSTR_CORRUPT: assert property (dbg_instr.valid && halted && dbg_instr.cls == VDQ_CLS_COMPARE_NOT_EQUAL_INSTR |=>
    dbg_action == VDQ_ACT_NORMAL && dbg_regs_corrupt) // see RULE_14
    else $error("compare-not-equal did not corrupt debug registers");
  AST_OTHER_UNDEF: assert property (dbg_instr.valid && halted && dbg_instr.cls != VDQ_CLS_LISTED &&
    dbg_instr.cls != VDQ_CLS_COMPARE_NOT_EQUAL_INSTR && pol == `VDQ_POL_UNDEF |=> dbg_action == VDQ_ACT_UNDEF) // see RULE_15
    else $error("undef policy not honoured");
  AST_IRQ_LEVEL: assert property (|(status_r & irq_en_r) |-> irq)
    else $error("interrupt low with enabled status");
  // Strong form of the inactive-lane rule: no event and no recording at all
  AST_INACTIVE_NO_RECORD: assert property (wp_req.valid && !(|(wp_req.active & wp_req.match)) |=> // see RULE_05
    !wp_event && ffr_clear == 8'h00)
    else $error("inactive lane match was reported");
  AST_ILLEGAL_STRICT: assert property (addr_hit && !legal_prefix && !ctrl_r[`VDQ_CTRL_BKPT_LOOSE] |=> // see RULE_10
    !bkpt_exc)
    else $error("strict setting still raised breakpoint");
  AST_FLAGS_EXECUTED: assert property (flags_unknown |-> dbg_action == VDQ_ACT_NORMAL) // see RULE_15
    else $error("unknown flags on an instruction that did not execute");
  AST_STATUS_STICKY: assert property (status_r[`VDQ_ST_WP_EVENT] && !clr_stb[`VDQ_ST_WP_EVENT] |=>
    status_r[`VDQ_ST_WP_EVENT])
    else $error("status bit dropped without a clear");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");

  CVR_FF_RECORD: cover property (wp_req.kind == VDQ_LD_FIRST_FAULT && |rec_vec);
  CVR_NORMAL_EVENT: cover property (wp_event ##1 irq);
  CVR_PREFIX_BKPT: cover property (bkpt_exc && step_covers_pair);
  CVR_COMPARE_NOT_EQUAL_INSTR_DBG: cover property (dbg_regs_corrupt);
  CVR_HALT_UNDEF: cover property (dbg_action_valid && dbg_action == VDQ_ACT_UNDEF);

endmodule

// >>> logic/vdq_consts.svh
// Register offsets, field positions and reset values of the vector debug event qualifier
`ifndef VDQ_CONSTS_SVH
`define VDQ_CONSTS_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VDQ_OFF_CTRL 8'h00
`define VDQ_OFF_BKPT_ADDR 8'h04
`define VDQ_OFF_STATUS 8'h08
`define VDQ_OFF_IRQ_EN 8'h0C
`define VDQ_OFF_IRQ_CLR 8'h10
`define VDQ_OFF_FFR 8'h14
`define VDQ_OFF_WP_ELEM 8'h18
// ****************************************************************
// Control fields
// ****************************************************************
`define VDQ_CTRL_WP_EN 0
`define VDQ_CTRL_BKPT_EN 1
`define VDQ_CTRL_STEP_PAIR 2
`define VDQ_CTRL_BKPT_LOOSE 3
`define VDQ_CTRL_DBG_POL_LO 4
`define VDQ_CTRL_DBG_POL_HI 5
`define VDQ_CTRL_RESET 6'h00
`define VDQ_CTRL_W 6
// ****************************************************************
// Status bits and debug policy codes
// ****************************************************************
`define VDQ_ST_WP_EVENT 0
`define VDQ_ST_FFR_REC 1
`define VDQ_ST_BKPT 2
`define VDQ_ST_DBG_CORRUPT 3
`define VDQ_ST_W 4
`define VDQ_ST_RESET 4'h0
`define VDQ_POL_NORMAL 2'h0
`define VDQ_POL_UNDEF 2'h1
`define VDQ_POL_NOP 2'h2
`endif

// >>> logic/vdq_pkg.sv
// Types shared by the vector debug event qualifier
package vdq_pkg;
  typedef enum logic [1:0] {VDQ_LD_NORMAL, VDQ_LD_FIRST_FAULT, VDQ_LD_NON_FAULT} vdq_ld_kind_type;
  typedef enum logic [2:0] {VDQ_CLS_LISTED, VDQ_CLS_COMPARE_NOT_EQUAL_INSTR, VDQ_CLS_OTHER_PLAIN, VDQ_CLS_OTHER_PROCESSOR_STATE,
                            VDQ_CLS_OTHER_FLAGS} vdq_dbg_class_type;
  typedef enum logic [1:0] {VDQ_ACT_NORMAL, VDQ_ACT_UNDEF, VDQ_ACT_NOP} vdq_dbg_action_type;
  typedef struct packed {
    logic valid;
    vdq_ld_kind_type kind;
    logic [7:0] active;
    logic [7:0] match;
    logic [7:0] nonspec;
  } vdq_wp_req_type;
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic is_prefix;
    logic prefix_legal;
    logic next_is_brk_hlt;
    logic is_prefixed;
    logic stepping;
  } vdq_commit_type;
  typedef struct packed {
    logic valid;
    vdq_dbg_class_type cls;
  } vdq_dbg_instr_type;
endpackage

// >>> tb/vdq_dbg_host.sv
// Debugger-side model: reaches the qualifier's registers over APB
`timescale 1ns/1ps
module vdq_dbg_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // No cycle count assumed: the bench watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    // Released lines show the inverse, so a stale value never looks valid
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// >>> tb/vdq_qualifier_tb.sv
// Self-checking bench for the vector debug event qualifier
`timescale 1ns/1ps
`include "vdq_consts.svh"
module vdq_qualifier_tb
  import vdq_pkg::*;
;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  vdq_wp_req_type wp_req = '0;
  vdq_commit_type commit = '0;
  vdq_dbg_instr_type dbg_instr = '0;
  logic halted = 1'h0;
  logic ffr_write_en = 1'h0;
  logic [7:0] ffr_write_val = 8'h00;
  logic access_proceed, wp_event, bkpt_exc, step_done, step_covers_pair, vstate_access_ok;
  logic dbg_action_valid, dbg_regs_corrupt, flags_unknown, irq;
  logic [7:0] ffr_clear;
  vdq_dbg_action_type dbg_action;
  int n_errors = 0;
  int checks = 0;
  typedef struct packed {
    vdq_ld_kind_type kind;
    logic [7:0] act;
    logic [7:0] hit;
    logic ev;
    logic [7:0] clr;
  } vdq_row_type;
  // Watchpoint cases for all three load kinds: load kind, active mask, matches, expected event and clear
  vdq_row_type rows [6] = '{
    '{VDQ_LD_NORMAL, 8'h0F, 8'h04, 1'h1, 8'h00},
    '{VDQ_LD_NORMAL, 8'h0F, 8'hF0, 1'h0, 8'h00},
    '{VDQ_LD_FIRST_FAULT, 8'h0E, 8'h02, 1'h1, 8'h00},
    '{VDQ_LD_FIRST_FAULT, 8'h0E, 8'h08, 1'h0, 8'hF8},
    '{VDQ_LD_NON_FAULT, 8'hFF, 8'h01, 1'h0, 8'hFF},
    '{VDQ_LD_NON_FAULT, 8'hF0, 8'h0F, 1'h0, 8'h00}
  };
  // Clock, 50 ns period
  always #25 pclk = ~pclk;
  vdq_dbg_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  vdq_qualifier #(.NELEM(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wp_req(wp_req), .commit(commit), .dbg_instr(dbg_instr), .halted(halted),
    .ffr_write_en(ffr_write_en), .ffr_write_val(ffr_write_val), .access_proceed(access_proceed),
    .wp_event(wp_event), .ffr_clear(ffr_clear), .bkpt_exc(bkpt_exc), .step_done(step_done),
    .step_covers_pair(step_covers_pair), .vstate_access_ok(vstate_access_ok), .dbg_action(dbg_action),
    .dbg_action_valid(dbg_action_valid), .dbg_regs_corrupt(dbg_regs_corrupt),
    .flags_unknown(flags_unknown), .irq(irq));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic err;
    u_host.xfer(1'h1, a, d, q, err);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] q;
    logic err;
    u_host.xfer(1'h0, a, 32'h0, q, err);
    chk(q, e, "read data");
    chk(err, ee, "slave error");
  endtask
  // One-cycle watchpoint request; answer looked at in the following cycle
  task automatic wp(input vdq_ld_kind_type k, input logic [7:0] a, m);
    @(posedge pclk);
    wp_req <= '{valid: 1'h1, kind: k, active: a, match: m, nonspec: 8'hFF};
    @(posedge pclk);
    wp_req <= '0;
    @(negedge pclk);
  endtask
  task automatic cm(input logic [31:0] pc, input logic lg, software_breakpoint_instr, st, ex);
    @(posedge pclk);
    commit <= '{valid: 1'h1, pc: pc, is_prefix: 1'h1, prefix_legal: lg,
                next_is_brk_hlt: software_breakpoint_instr, is_prefixed: 1'h0, stepping: st};
    @(posedge pclk);
    commit <= '0;
    @(negedge pclk);
    chk(bkpt_exc, ex, "breakpoint");
  endtask
  task automatic di(input vdq_dbg_class_type c, input vdq_dbg_action_type a, input logic cor, flg);
    @(posedge pclk);
    dbg_instr <= '{valid: 1'h1, cls: c};
    @(posedge pclk);
    dbg_instr <= '0;
    @(negedge pclk);
    chk(dbg_action_valid, 1'h1, "action valid");
    chk(dbg_action, a, "debug action");
    chk(dbg_regs_corrupt, cor, "link and status corrupt");
    chk(flags_unknown, flg, "flags unknown");
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge pclk);
    n_errors++;
    $display("wrong value at %0t: run did not finish", $time);
    test_done();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (5) @(posedge pclk);
    chk({irq, wp_event, pready, bkpt_exc}, 4'h0, "outputs in reset");
    presetn <= 1'h1;
    rd(`VDQ_OFF_CTRL, 32'h0, 1'h0);
    rd(`VDQ_OFF_FFR, 32'hFF, 1'h0);
    rd(`VDQ_OFF_STATUS, 32'h0, 1'h0);
    // Disabled watchpoints give no event, yet the access still goes ahead
    wp(VDQ_LD_NORMAL, 8'h0F, 8'h04);
    chk(wp_event, 1'h0, "event while disabled");
    chk(access_proceed, 1'h1, "access held back");
    $display("test reset done");
    wr(`VDQ_OFF_CTRL, 32'h1);
    foreach (rows[i]) begin
      wp(rows[i].kind, rows[i].act, rows[i].hit);
      chk(wp_event, rows[i].ev, "watchpoint event");
      chk(ffr_clear, rows[i].clr, "first-fault clear");
      chk(access_proceed, 1'h1, "access held back");
    end
    $display("test watchpoint table done");
    // Status is sticky and masked until enabled; write-one clears it
    rd(`VDQ_OFF_STATUS, 32'h3, 1'h0);
    rd(`VDQ_OFF_WP_ELEM, 32'h2, 1'h0);
    chk(irq, 1'h0, "irq while masked");
    wr(`VDQ_OFF_IRQ_EN, 32'h1);
    rd(`VDQ_OFF_IRQ_CLR, 32'h0, 1'h0);
    chk(irq, 1'h1, "irq enabled");
    wr(`VDQ_OFF_IRQ_CLR, 32'h3);
    rd(`VDQ_OFF_STATUS, 32'h0, 1'h0);
    chk(irq, 1'h0, "irq after clear");
    rd(8'h40, 32'h0, 1'h1);
    $display("test interrupt done");
    // Recording clears the matched element and all above it in the register
    @(posedge pclk);
    ffr_write_en <= 1'h1;
    ffr_write_val <= 8'hFF;
    @(posedge pclk);
    ffr_write_en <= 1'h0;
    wp(VDQ_LD_FIRST_FAULT, 8'h0E, 8'h08);
    rd(`VDQ_OFF_FFR, 32'h07, 1'h0);
    $display("test first-fault register done");
    wr(`VDQ_OFF_BKPT_ADDR, 32'h1000);
    wr(`VDQ_OFF_CTRL, 32'h7);
    cm(32'h1000, 1'h1, 1'h0, 1'h0, 1'h1);
    cm(32'h1000, 1'h0, 1'h1, 1'h0, 1'h1);
    cm(32'h1004, 1'h1, 1'h0, 1'h0, 1'h0);
    cm(32'h1000, 1'h1, 1'h0, 1'h1, 1'h1);
    chk({step_done, step_covers_pair}, 2'h3, "step over pair");
    wr(`VDQ_OFF_CTRL, 32'h3);
    cm(32'h2000, 1'h1, 1'h0, 1'h1, 1'h0);
    chk({step_done, step_covers_pair}, 2'h2, "step over prefix");
    // Illegal prefix: the loose control bit picks between the two allowed outcomes
    cm(32'h1000, 1'h0, 1'h0, 1'h0, 1'h0);
    wr(`VDQ_OFF_CTRL, 32'hA);
    cm(32'h1000, 1'h0, 1'h0, 1'h0, 1'h1);
    $display("test breakpoint and step done");
    @(posedge pclk);
    halted <= 1'h1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(vstate_access_ok, 1'h1, "vector state access");
    wr(`VDQ_OFF_CTRL, 32'h10);
    di(VDQ_CLS_LISTED, VDQ_ACT_NORMAL, 1'h0, 1'h0);
    di(VDQ_CLS_COMPARE_NOT_EQUAL_INSTR, VDQ_ACT_NORMAL, 1'h1, 1'h0);
    di(VDQ_CLS_OTHER_PLAIN, VDQ_ACT_UNDEF, 1'h0, 1'h0);
    wr(`VDQ_OFF_CTRL, 32'h20);
    di(VDQ_CLS_OTHER_PROCESSOR_STATE, VDQ_ACT_NOP, 1'h0, 1'h0);
    wr(`VDQ_OFF_CTRL, 32'h0);
    di(VDQ_CLS_OTHER_PROCESSOR_STATE, VDQ_ACT_NORMAL, 1'h1, 1'h0);
    di(VDQ_CLS_OTHER_FLAGS, VDQ_ACT_NORMAL, 1'h0, 1'h1);
    $display("test debug state done");
    test_done();
  end
endmodule
